// file: rbc_defines.svh
// Offsets, field positions, reset values and timing counts for the
// raster engine bus cycle unit. Assumes byte addressing on a 32-bit APB.
`ifndef RBC_DEFINES_SVH
`define RBC_DEFINES_SVH
// Register byte offsets
`define RBC_CTRL_OFF 8'h00
`define RBC_ADDR_OFF 8'h04
`define RBC_WDATA_OFF 8'h08
`define RBC_RDATA_OFF 8'h0C
`define RBC_STAT_OFF 8'h10
`define RBC_PSW_OFF 8'h14
`define RBC_VCR_OFF 8'h18
`define RBC_PC_OFF 8'h1C
`define RBC_RFADDR_OFF 8'h20
// Command register fields
`define RBC_CTRL_KIND 2:0
`define RBC_CTRL_GO 3
`define RBC_CTRL_BSEL 7:4
// Status word bits
`define RBC_PSW_VIE 0
`define RBC_PSW_EIE 1
`define RBC_PSW_TRAP 2
`define RBC_PSW_CLIP 3
`define RBC_PSW_NMI 8
// Video control fields
`define RBC_VCR_VRX 3:0
`define RBC_VCR_SE 4
`define RBC_VCR_SM 5
`define RBC_VCR_SI 6
`define RBC_VCR_SC 7
`define RBC_VCR_RM 9:8
`define RBC_VCR_RAI 10
// Reset values
`define RBC_PC_RST 24'h000000
`define RBC_PSW_RST 4'h0
`define RBC_VCR_RST 11'h000
// Refresh request interval
`define RBC_CLK_NS 10
`define RBC_RF_PERIOD_NS 640
`define RBC_RF_CYCLES (`RBC_RF_PERIOD_NS / `RBC_CLK_NS)
`endif

// file: rbc_pkg.sv
// Types shared by the raster engine bus cycle unit.
// Assumes the defines header supplies all numeric constants.
package rbc_pkg;
  // Bus cycle sequencer states
  typedef enum logic [2:0] {
    S_IDLE = 3'b000,
    S_T1 = 3'b001,
    S_T2 = 3'b010,
    S_T3 = 3'b011,
    S_HOLD = 3'b100
  } rbc_state_t;
  // Bus cycle kinds
  typedef enum logic [2:0] {
    K_OP_RD = 3'b000,
    K_OP_WR = 3'b001,
    K_FETCH = 3'b010,
    K_REFRESH = 3'b011,
    K_BLT_SRC = 3'b100,
    K_BLT_DST_WR = 3'b101,
    K_BLT_RMW = 3'b110,
    K_LINE_RMW = 3'b111
  } rbc_kind_t;
endpackage : rbc_pkg

// file: rbc_bus_cycle_unit.sv
// Bus cycle generator of a raster graphics processor with APB registers.
// Assumes one pclk cycle per T state; pins are synchronised here.
// Functional notes
// (RULE1) Reset zeroes program counter; fetches from zero
// (RULE2) Reset clears status word enable bits
// (RULE3) Reset clears video control register fields
// (RULE4) All interrupts stay disabled until enabled
// (RULE5) First status word write enables nonmaskable
// (RULE6) Glue treats read/write status as status only
// (RULE7) Address latch enable marks each cycle start
// (RULE8) Non-drawing: 24-bit address, 16-bit data
// (RULE9) Operand cycle: status 00, read/write by direction
// (RULE10) Fetch: status bit0 1, bit1 0, read
// (RULE11) Refresh: status 11, read, on own request
// (RULE12) Non-drawing cycles take three T states minimum
// (RULE13) Second T state repeats until wait high
// (RULE14) Status outputs static during wait loop
// (RULE15) Read data captured in third T state
// (RULE16) Blit source read status encoding
// (RULE17) Blit destination write status encoding
// (RULE18) Blit read-modify-write status encoding
// (RULE19) Line read-modify-write with bit select
// (RULE20) Drawing cycles two T states, back to back
// (RULE21) Hold: finish cycle, float lines, acknowledge
// (RULE22) Refresh request keeps working during hold
// (RULE23) Refresh request per selected refresh mode
// (RULE24) Other master drives only after acknowledge
//
// The APB slave port and the placing of the registers are this design's own decisions.
`include "rbc_defines.svh"
`timescale 1ns/1ps
module rbc_bus_cycle_unit
  import rbc_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [15:0] muxed_addr_data_in,
  output logic [23:0] muxed_addr_data_out,
  output logic [23:0] muxed_addr_data_oe,
  output logic addr_latch_enable,
  output logic bus_status_bit0,
  output logic bus_status_bit1,
  output logic read_status_n,
  output logic write_status_n,
  output logic line_blit_select,
  output logic [3:0] bit_select_outputs,
  input wire logic bus_wait_release,
  input wire logic bus_hold_req_n,
  output logic bus_hold_ack_n,
  output logic refresh_request_n
);
  // Status pattern {line/blit, bit1, bit0, read_n, write_n} per kind
  function automatic logic [4:0] kind_status(input rbc_kind_t k);
    unique case (k)
      K_OP_RD: kind_status = 5'h01;
      K_OP_WR: kind_status = 5'h02;
      // (RULE10) Fetch status encoding
      K_FETCH: kind_status = 5'h05;
      K_REFRESH: kind_status = 5'h0D;
      // (RULE16) Blit source read encoding
      K_BLT_SRC: kind_status = 5'h09;
      // (RULE17) Blit destination write encoding
      K_BLT_DST_WR: kind_status = 5'h0A;
      // (RULE18) Blit read-modify-write encoding
      K_BLT_RMW: kind_status = 5'h08;
      K_LINE_RMW: kind_status = 5'h18;
    endcase
  endfunction : kind_status
  // Drawing cycles end after the wait loop, with no third T state
  function automatic logic is_draw(input rbc_kind_t k);
    is_draw = k[2];
  endfunction : is_draw

  // Pin synchronisers, two stages each
  logic wait_meta;
  logic wait_s;
  logic hold_meta;
  logic hold_s_n;
  logic [15:0] din_meta;
  logic [15:0] din_s;
  // Sequencer and cycle context
  rbc_state_t state;
  rbc_state_t next_state;
  rbc_kind_t cur_kind;
  logic [23:0] cyc_addr;
  // Software command
  rbc_kind_t cmd_kind;
  logic [23:0] cmd_addr;
  logic [15:0] cmd_wdata;
  logic [3:0] cmd_bsel;
  logic cmd_pend;
  // Processor state
  logic [23:0] program_counter;
  logic [3:0] psw_en;
  logic nmi_en;
  logic [10:0] video_control_register;
  logic [15:0] rdata;
  // Refresh generator
  logic [23:0] rf_addr;
  logic [15:0] rf_cnt;
  logic rf_pend;
  // APB handshake
  logic ack;

  // Synchronise pins before any logic reads them
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      wait_meta <= 1'b0;
      wait_s <= 1'b0;
      hold_meta <= 1'b1;
      hold_s_n <= 1'b1;
      din_meta <= 16'h0000;
      din_s <= 16'h0000;
    end
    else
    begin
      wait_meta <= bus_wait_release;
      wait_s <= wait_meta;
      hold_meta <= bus_hold_req_n;
      hold_s_n <= hold_meta;
      din_meta <= muxed_addr_data_in;
      din_s <= din_meta;
    end
  end

  // APB decode: access completes on the second access cycle
  wire acc = psel & penable;
  wire wr_en = acc & pwrite & ack;
  wire hit_ctrl = paddr == `RBC_CTRL_OFF;
  wire hit_addr = paddr == `RBC_ADDR_OFF;
  wire hit_wdata = paddr == `RBC_WDATA_OFF;
  wire hit_rdata = paddr == `RBC_RDATA_OFF;
  wire hit_stat = paddr == `RBC_STAT_OFF;
  wire hit_psw = paddr == `RBC_PSW_OFF;
  wire hit_vcr = paddr == `RBC_VCR_OFF;
  wire hit_pc = paddr == `RBC_PC_OFF;
  wire hit_rf = paddr == `RBC_RFADDR_OFF;
  wire hit_any = hit_ctrl | hit_addr | hit_wdata | hit_rdata | hit_stat
    | hit_psw | hit_vcr | hit_pc | hit_rf;
  wire wr_psw = wr_en & hit_psw;
  wire go_req = wr_en & hit_ctrl & pwdata[`RBC_CTRL_GO];
  wire [31:0] rd_mux =
    hit_ctrl ? {24'h000000, cmd_bsel, 1'b0, cmd_kind} :
    hit_addr ? {8'h00, cmd_addr} :
    hit_wdata ? {16'h0000, cmd_wdata} :
    hit_rdata ? {16'h0000, rdata} :
    hit_stat ? {26'h0000000, rf_pend, cmd_pend, ~hold_s_n, state} :
    hit_psw ? {23'h000000, nmi_en, 4'h0, psw_en} :
    hit_vcr ? {21'h000000, video_control_register} :
    hit_pc ? {8'h00, program_counter} :
    hit_rf ? {8'h00, rf_addr} : 32'h00000000;
  assign pready = ack;
  assign pslverr = ack & ~hit_any;

  // APB answer flops
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ack <= 1'b0;
      prdata <= 32'h00000000;
    end
    else
    begin
      ack <= acc & ~ack;
      // Read data is registered in the first access cycle
      if (acc & ~ack & ~pwrite)
        prdata <= rd_mux;
    end
  end

  // Arbitration at the end of each cycle or when idle
  wire hold_req = ~hold_s_n;
  wire end_draw = (state == S_T2) & wait_s & is_draw(cur_kind);
  wire cycle_free = (state == S_IDLE) | (state == S_T3) | end_draw;
  wire launch = cycle_free & ~hold_req & (rf_pend | cmd_pend);
  wire rf_launch = launch & rf_pend;
  wire cmd_launch = launch & ~rf_pend;
  wire rbc_kind_t kind_sel = rf_pend ? K_REFRESH : cmd_kind;
  wire [23:0] addr_sel = rf_pend ? rf_addr :
    (cmd_kind == K_FETCH) ? program_counter : cmd_addr;
  wire rbc_kind_t next_kind = launch ? kind_sel : cur_kind;
  wire next_busy = (next_state == S_T1) | (next_state == S_T2)
    | (next_state == S_T3);
  wire drive_data = next_kind == K_OP_WR;
  wire fetch_done = (state == S_T3) & (cur_kind == K_FETCH);
  wire read_done = (state == S_T3) & (cur_kind != K_OP_WR);
  wire rf_tick = (video_control_register[`RBC_VCR_RM] != 2'b00)
    & (rf_cnt == 16'(`RBC_RF_CYCLES - 1));

  // Next state of the T-state sequencer
  always_comb
  begin
    next_state = state;
    unique case (state)
      S_IDLE: next_state = S_IDLE;
      S_T1: next_state = S_T2;
      // (RULE13) Wait loop in T2
      S_T2: if (wait_s && !is_draw(cur_kind)) next_state = S_T3;
      S_T3: next_state = S_IDLE;
      S_HOLD: if (!hold_req) next_state = S_IDLE;
      default: next_state = S_IDLE;
    endcase
    // (RULE21) Hold granted only between cycles
    if (cycle_free)
      next_state = hold_req ? S_HOLD : launch ? S_T1 : S_IDLE;
  end

  // Sequencer state and cycle context
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state <= S_IDLE;
      cur_kind <= K_OP_RD;
      cyc_addr <= 24'h000000;
    end
    else
    begin
      state <= next_state;
      if (launch)
      begin
        cur_kind <= kind_sel;
        cyc_addr <= addr_sel;
      end
    end
  end

  // Pin outputs, all from flops; idle status is read/write high
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      {line_blit_select, bus_status_bit1, bus_status_bit0} <= 3'h0;
      {read_status_n, write_status_n} <= 2'h3;
      addr_latch_enable <= 1'b0;
      muxed_addr_data_out <= 24'h000000;
      muxed_addr_data_oe <= 24'h000000;
      bit_select_outputs <= 4'h0;
      bus_hold_ack_n <= 1'b1;
    end
    else
    begin
      // (RULE7) One strobe in the first T state
      addr_latch_enable <= launch;
      bus_hold_ack_n <= next_state != S_HOLD;
      // (RULE8) High byte held, low word drives data on writes
      muxed_addr_data_oe <= {{8{next_busy}},
        {16{(next_state == S_T1) | (next_busy & drive_data)}}};
      if (launch)
      begin
        // (RULE9) Status fixed for the whole cycle
        {line_blit_select, bus_status_bit1, bus_status_bit0,
          read_status_n, write_status_n} <= kind_status(kind_sel);
        muxed_addr_data_out <= addr_sel;
        // (RULE19) Bit select for line drawing
        bit_select_outputs <= cmd_bsel;
      end
      else if (state == S_T1 && drive_data)
        muxed_addr_data_out <= {cyc_addr[23:16], cmd_wdata};
      else if (!next_busy)
      begin
        {line_blit_select, bus_status_bit1, bus_status_bit0} <= 3'h0;
        {read_status_n, write_status_n} <= 2'h3;
      end
    end
  end

  // Software command holding register
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cmd_kind <= K_OP_RD;
      cmd_addr <= 24'h000000;
      cmd_wdata <= 16'h0000;
      cmd_bsel <= 4'h0;
      cmd_pend <= 1'b0;
    end
    else
    begin
      // Command fields are frozen while one is pending
      if (wr_en & hit_ctrl & ~cmd_pend)
      begin
        cmd_kind <= rbc_kind_t'(pwdata[`RBC_CTRL_KIND]);
        cmd_bsel <= pwdata[`RBC_CTRL_BSEL];
      end
      if (wr_en & hit_addr & ~cmd_pend)
        cmd_addr <= pwdata[23:0];
      if (wr_en & hit_wdata & ~cmd_pend)
        cmd_wdata <= pwdata[15:0];
      cmd_pend <= (go_req & ~cmd_pend) | (cmd_pend & ~cmd_launch);
    end
  end

  // Processor state registers
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      // (RULE1) Program counter starts at zero
      program_counter <= `RBC_PC_RST;
      // (RULE2) Enable bits cleared
      psw_en <= `RBC_PSW_RST;
      // (RULE5) Nonmaskable disabled until first write
      nmi_en <= 1'b0;
      // (RULE3) Video control cleared
      video_control_register <= `RBC_VCR_RST;
      rdata <= 16'h0000;
    end
    else
    begin
      // (RULE1) Fetch address advances per fetch
      if (fetch_done)
        program_counter <= program_counter + 24'h000001;
      else if (wr_en & hit_pc)
        program_counter <= pwdata[23:0];
      // (RULE4) Enables change only by software
      if (wr_psw)
        psw_en <= pwdata[3:0];
      // (RULE5) Any status word write arms it
      if (wr_psw)
        nmi_en <= 1'b1;
      if (wr_en & hit_vcr)
        video_control_register <= pwdata[10:0];
      // (RULE15) Data taken in the third T state
      if (read_done)
        rdata <= din_s;
    end
  end

  // Refresh request generator, runs during hold as well
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      rf_cnt <= 16'h0000;
      rf_pend <= 1'b0;
      rf_addr <= 24'h000000;
      refresh_request_n <= 1'b1;
    end
    else
    begin
      // (RULE23) Interval counts only with a mode selected
      if (video_control_register[`RBC_VCR_RM] == 2'b00 || rf_tick)
        rf_cnt <= 16'h0000;
      else
        rf_cnt <= rf_cnt + 16'h0001;
      // (RULE22) New request wins over service
      rf_pend <= rf_tick | (rf_pend & ~rf_launch);
      refresh_request_n <= ~(rf_tick | (rf_pend & ~rf_launch));
      if (wr_en & hit_rf)
        rf_addr <= pwdata[23:0];
      else if (rf_launch & video_control_register[`RBC_VCR_RAI])
        rf_addr <= rf_addr + 24'h000001;
    end
  end

  // Checks on the documented bus behaviour
  wire [4:0] pin_status = {line_blit_select, bus_status_bit1,
    bus_status_bit0, read_status_n, write_status_n};
  sequence seq_t1_nd;
    (state == S_T1) && !is_draw(cur_kind);
  endsequence
  sequence seq_t2_wait_over;
    (state == S_T2) && wait_s;
  endsequence

  chk_reset_clears: assert property ( // (RULE3)
    @(posedge pclk) $rose(presetn) |->
      video_control_register == 11'h000 && psw_en == 4'h0 && !nmi_en)
    else $error("reset state not cleared");
  chk_nmi_arming: assert property ( // (RULE5)
    @(posedge pclk) disable iff (!presetn)
      !nmi_en && !wr_psw |=> !nmi_en)
    else $error("nmi enabled without status word write");
  chk_fetch_pc: assert property ( // (RULE1)
    @(posedge pclk) disable iff (!presetn)
      fetch_done |=> program_counter == $past(program_counter) + 24'h1)
    else $error("program counter did not advance");
  chk_ale_t1: assert property ( // (RULE7)
    @(posedge pclk) disable iff (!presetn)
      addr_latch_enable == (state == S_T1))
    else $error("latch enable outside first T state");
  chk_nd_three: assert property ( // (RULE12)
    @(posedge pclk) disable iff (!presetn)
      seq_t1_nd ##1 seq_t2_wait_over |=> state == S_T3)
    else $error("non-drawing cycle skipped third T state");
  chk_wait_loop: assert property ( // (RULE13)
    @(posedge pclk) disable iff (!presetn)
      (state == S_T2) && !wait_s |=> state == S_T2)
    else $error("left wait loop without wait high");
  chk_t2_static: assert property ( // (RULE14)
    @(posedge pclk) disable iff (!presetn)
      (state == S_T2) ##1 (state == S_T2) |-> $stable(pin_status))
    else $error("status moved in wait loop");
  chk_cycle_status: assert property ( // (RULE9)
    @(posedge pclk) disable iff (!presetn)
      state == S_T1 |-> pin_status == kind_status(cur_kind))
    else $error("cycle status does not match kind");
  chk_refresh_status: assert property ( // (RULE11)
    @(posedge pclk) disable iff (!presetn)
      state == S_T1 && cur_kind == K_REFRESH |-> pin_status == 5'h0D)
    else $error("refresh cycle status wrong");
  chk_draw_end: assert property ( // (RULE20)
    @(posedge pclk) disable iff (!presetn)
      end_draw |=> state != S_T2 && state != S_T3)
    else $error("drawing cycle overran");
  chk_hold_float: assert property ( // (RULE21)
    @(posedge pclk) disable iff (!presetn)
      state == S_HOLD |-> !bus_hold_ack_n && muxed_addr_data_oe == 24'h0)
    else $error("hold without float and acknowledge");
  chk_hold_refresh: assert property ( // (RULE22)
    @(posedge pclk) disable iff (!presetn)
      state == S_HOLD && rf_tick |=> rf_pend && !refresh_request_n)
    else $error("refresh request lost during hold");
endmodule : rbc_bus_cycle_unit

// file: rbc_glue_model.sv
// Glue and memory model on the far side of the bus cycle pins.
// Assumes the bench resolves the shared data lines from the enables.
`timescale 1ns/1ps
module rbc_glue_model
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic addr_latch_enable,
  input wire logic [23:0] muxed_addr_data_out,
  input wire logic [3:0] wait_len,
  output logic bus_wait_release,
  output logic [15:0] mem_data
);
  logic [15:0] adr; // Low address taken at cycle start
  logic [3:0] cnt; // Wait states still to insert
  logic busy; // Cycle seen, release not yet given
  logic [3:0] hold; // Cycles that read data still stands
  // data stands
  // Data is valid while release is up, then flips to its inverse
  assign mem_data = (hold != 4'h0) ? ~adr : adr;
  // wait release
  // Start taken from the latch pulse only, never from read or write
  // status; release comes wait_len + 1 cycles later and stays a while
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      adr <= 16'h0000;
      cnt <= 4'h0;
      busy <= 1'b0;
      hold <= 4'h0;
      bus_wait_release <= 1'b0;
    end
    else if (addr_latch_enable)
    begin
      adr <= muxed_addr_data_out[15:0];
      cnt <= wait_len;
      busy <= 1'b1;
      bus_wait_release <= 1'b0;
    end
    else if (busy && cnt != 4'h0)
      cnt <= cnt - 4'h1;
    else if (busy)
    begin
      busy <= 1'b0;
      hold <= 4'h8;
      bus_wait_release <= 1'b1;
    end
    else if (hold != 4'h0)
    begin
      hold <= hold - 4'h1;
      // Release dropped once the data has gone
      if (hold == 4'h1)
        bus_wait_release <= 1'b0;
    end
  end
endmodule : rbc_glue_model

// file: raster_engine_bus_cycle_unit_tb_top.sv
// Self-checking bench for the raster engine bus cycle unit.
// Assumes the glue model answers every cycle; APB drives registers.
`include "rbc_defines.svh"
`timescale 1ns/1ps
module raster_engine_bus_cycle_unit_tb_top;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic hreq_n = 1'b1; // Hold request from the other master
  logic [3:0] wlen = 4'h0; // Wait states the glue inserts
  logic [31:0] prdata, q;
  logic pready, pslverr, ale, bs0, bs1, rdn, wrn, lbs;
  logic wrel, hack_n, rreq_n, serr;
  logic [23:0] dout, oe;
  logic [15:0] bus_in, mdat;
  logic [3:0] bsel;
  logic [4:0] st; // {bit0, bit1, read_n, write_n, line}
  int err_total = 0;
  int n_checks = 0;
  int cyc = 0;
  // Expected status per cycle kind code
  logic [4:0] exp_st [0:7] = '{5'h02, 5'h04, 5'h12, 5'h1A,
    5'h0A, 5'h0C, 5'h08, 5'h09};
  // Free running clock
  always #5 pclk = ~pclk;
  assign st = {bs0, bs1, rdn, wrn, lbs};
  // Shared lines: design where enabled, glue elsewhere
  assign bus_in = (dout[15:0] & oe[15:0]) | (mdat & ~oe[15:0]);
  rbc_bus_cycle_unit i_dut (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .muxed_addr_data_in(bus_in),
    .muxed_addr_data_out(dout), .muxed_addr_data_oe(oe),
    .addr_latch_enable(ale), .bus_status_bit0(bs0),
    .bus_status_bit1(bs1), .read_status_n(rdn),
    .write_status_n(wrn), .line_blit_select(lbs),
    .bit_select_outputs(bsel), .bus_wait_release(wrel),
    .bus_hold_req_n(hreq_n), .bus_hold_ack_n(hack_n),
    .refresh_request_n(rreq_n));
  rbc_glue_model i_glue (.pclk(pclk), .presetn(presetn),
    .addr_latch_enable(ale), .muxed_addr_data_out(dout),
    .wait_len(wlen), .bus_wait_release(wrel), .mem_data(mdat));
  // Compare and count
  task automatic chk(input string nm, input logic [31:0] e,
    input logic [31:0] g);
    n_checks++;
    if (g !== e)
    begin
      err_total++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  // One APB transfer; request held until pready seen high
  task automatic apb(input logic w, input logic [7:0] a,
    input logic [31:0] d, output logic [31:0] r);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // Request stands until pready is sampled high at a rising edge
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata;
    serr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  // Launch one bus cycle of kind k and follow it to its end
  task automatic run_cyc(input int k);
    logic [23:0] a;
    logic [23:0] ca;
    logic [31:0] r;
    logic [31:0] last;
    logic [4:0] s0;
    int n;
    a = 24'hA50000 + 24'(k * 'h111);
    @(posedge pclk);
    wlen <= 4'(k);
    apb(1'b1, `RBC_ADDR_OFF, 32'(a), r);
    apb(1'b1, `RBC_WDATA_OFF, 32'h1230 + 32'(k), r);
    apb(1'b1, `RBC_CTRL_OFF, {24'h0, 4'(15 - k), 1'b1, 3'(k)}, r);
    do @(negedge pclk); while (ale !== 1'b1);
    s0 = st;
    ca = dout;
    chk("status", 32'(exp_st[k]), 32'(s0));
    chk("status_rw", 32'(exp_st[k]), 32'(s0));
    chk("oe_first", 32'hFFFFFF, 32'(oe));
    if (k != 3)
      chk("addr", (k == 2) ? 32'h0 : 32'(a), 32'(ca));
    if (k == 7)
      chk("bitsel", 32'(15 - k), 32'(bsel));
    n = 0;
    while (st !== 5'h06)
    begin
      chk("held", 32'(s0), 32'(st));
      if (n > 0)
        chk("ale_once", 32'h0, 32'(ale));
      n++;
      last = {oe[15:0], dout[15:0]};
      @(negedge pclk);
    end
    chk("tstates", 32'h1, 32'(n >= ((k > 3) ? 2 : 3)));
    if (k == 1)
      chk("wdata", 32'hFFFF1231, last);
    if (k == 0 || k == 2 || k == 3)
    begin
      apb(1'b0, `RBC_RDATA_OFF, 32'h0, r);
      chk("rdata", {16'h0, ~((k == 2) ? 16'h0 : a[15:0])}, r);
    end
  endtask : run_cyc
  // Prints counts and verdict, ends the run
  task automatic report_and_stop;
    $display("checks %0d errors %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : report_and_stop
  // Watchdog against a hung wait
  always @(posedge pclk)
  begin
    cyc <= cyc + 1;
    if (cyc == 6000)
    begin
      err_total++;
      report_and_stop();
    end
  end
  // Main sequence
  initial
  begin
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    chk("idle_st", 32'h06, 32'(st));
    chk("rreq_rst", 32'h1, 32'(rreq_n));
    apb(1'b0, `RBC_PC_OFF, 32'h0, q);
    chk("pc_rst", 32'h0, q);
    apb(1'b0, `RBC_PSW_OFF, 32'h0, q);
    chk("psw_rst", 32'h0, q);
    apb(1'b0, `RBC_VCR_OFF, 32'h0, q);
    chk("vcr_rst", 32'h0, q);
    apb(1'b0, 8'h40, 32'h0, q);
    chk("unmapped", 32'h1, {31'h0, serr});
    apb(1'b1, `RBC_PSW_OFF, 32'h0, q);
    apb(1'b0, `RBC_PSW_OFF, 32'h0, q);
    chk("nmi_on", 32'h100, q);
    apb(1'b1, `RBC_PSW_OFF, 32'hF, q);
    apb(1'b0, `RBC_PSW_OFF, 32'h0, q);
    chk("psw_set", 32'h10F, q);
    for (int k = 0; k < 8; k++)
      run_cyc(k);
    apb(1'b0, `RBC_PC_OFF, 32'h0, q);
    chk("pc_step", 32'h1, q);
    // The bench never drives the lines while holding
    @(posedge pclk);
    hreq_n <= 1'b0;
    do @(negedge pclk); while (hack_n !== 1'b0);
    chk("hold_oe", 32'h0, 32'(oe));
    chk("hold_st", 32'h06, 32'(st));
    apb(1'b1, `RBC_VCR_OFF, 32'h100, q);
    do @(negedge pclk); while (rreq_n !== 1'b0);
    chk("rf_in_hold", 32'h0, 32'(hack_n));
    @(posedge pclk);
    hreq_n <= 1'b1;
    do @(negedge pclk); while (ale !== 1'b1);
    chk("hold_off", 32'h1, 32'(hack_n));
    chk("rf_cycle", 32'h1A, 32'(st));
    apb(1'b1, `RBC_VCR_OFF, 32'h0, q);
    report_and_stop();
  end
endmodule : raster_engine_bus_cycle_unit_tb_top
